// ==== design/smbsp_pkg.sv ====
// smbsp_pkg: constants and types shared by both ends of the monitor port.
// assumes a 100 MHz system clock on both ends.
package smbsp_pkg;

    // ==========================================================
    // addressing
    localparam logic [4:0] SLV_PREFIX   = 5'h0B;
    localparam logic [1:0] STRAP_GND    = 2'h0;
    localparam logic [1:0] STRAP_OPEN   = 2'h1;
    localparam logic [1:0] STRAP_VCC    = 2'h2;
    localparam logic [1:0] SID_GND      = 2'h0;
    localparam logic [1:0] SID_OPEN     = 2'h2;
    localparam logic [1:0] SID_VCC      = 2'h1;
    localparam logic       DIR_WRITE    = 1'h0;
    localparam logic       DIR_READ     = 1'h1;
    localparam logic [3:0] BITS_BYTE    = 4'h8;
    localparam logic [1:0] MAX_WR_BYTES = 2'h2;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned CLK_FREQ_KHZ   = 100000;
    localparam int unsigned RST_PULSE_MS   = 20;
    localparam int unsigned RST_PULSE_CYC  = RST_PULSE_MS * CLK_FREQ_KHZ;
    localparam int unsigned RST_CNT_W      = 22;
    localparam int unsigned LINK_PERIOD_NS = 160;
    localparam int unsigned QTR_CYC_I      =
        LINK_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam logic [3:0]  QTR_CYC        = 4'(QTR_CYC_I);

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ROLE_ADDR, ROLE_RESET, ROLE_INT
    } smbsp_role_t;

    typedef enum logic [1:0] {
        OP_SET_PTR, OP_WRITE, OP_READ
    } smbsp_op_t;

    typedef enum logic [2:0] {
        D_IDLE, D_ADDR, D_AACK, D_WR, D_WACK, D_RD, D_IGNR
    } smbsp_dst_t;

    typedef enum logic [1:0] {
        H_IDLE, H_START, H_BIT, H_STOP
    } smbsp_hst_t;

endpackage

// ==== design/smbsp_if.sv ====
// smbsp_if: the two-wire management link plus the multi-role pin.
// assumes the bench drives pin_strap with the sensed three-state level.
`timescale 1ns/10ps
interface smbsp_if;
    logic       scl;
    logic       sda;
    logic       dev_sda_o;
    logic       dev_sda_oe_n;
    logic       host_sda_o;
    logic       host_sda_oe_n;
    logic [1:0] pin_strap;
    logic       pin_o;
    logic       pin_oe_n;

    // wired-and with pull-up: any enabled driver wins
    assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

    modport dev (
        input  scl,
        input  sda,
        input  pin_strap,
        output dev_sda_o,
        output dev_sda_oe_n,
        output pin_o,
        output pin_oe_n
    );

    modport host (
        input  sda,
        output scl,
        output host_sda_o,
        output host_sda_oe_n
    );
endinterface

// ==== design/smbsp_dev.sv ====
// smbsp_dev: slave end of the monitor's management port.
// assumes the register file answers i_rd_data for o_reg_addr at once.
`timescale 1ns/10ps

// Functional notes
// RQ1: address is prefix 01011 plus two strap bits
// RQ2: strap gnd 00, open 10, supply 01
// RQ3: open strap gives address 0101110
// RQ4: strap latched once at first activity
// RQ5: start is sda fall, then eight bits
// RQ6: ack own address, else idle till start
// RQ7: direction bit 0 write, 1 read
// RQ8: nine clocks per byte, slave acks writes
// RQ9: sda stable while scl high, rise=stop
// RQ10: master ends write with stop
// RQ11: master nacks read, then stop
// RQ12: direction fixed until next start
// RQ13: writes carry one or two bytes, reads one
// RQ14: first write byte loads the pointer
// RQ15: second write byte stored to pointed register
// RQ16: read returns pointed register, no pointer needed
// RQ17: master writes pointer first for other register
// RQ18: reset role gives 20 ms low pulse
// RQ19: interrupt role flags out-of-limit events
// RQ20: nand test mode drives tree output
// RQ21: strap not grounded when pin drives
// RQ22: after read nack, ignore until start
// RQ23: pointer kept until next write
module smbsp_dev #(
    parameter int unsigned RST_PULSE_CYC = smbsp_pkg::RST_PULSE_CYC
) (
    input  logic                   i_clk,
    input  logic                   i_rst_n,
    smbsp_if.dev                   bus,
    input  smbsp_pkg::smbsp_role_t i_role,
    input  logic                   i_nand_test,
    input  logic                   i_nand_tree,
    input  logic                   i_rst_fire,
    input  logic                   i_alert,
    input  logic [7:0]             i_rd_data,
    output logic [7:0]             o_reg_addr,
    output logic [7:0]             o_wr_data,
    output logic                   o_wr_stb,
    output logic [1:0]             o_slave_id
);
    import smbsp_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic                 scl_m;
        logic                 scl_s;
        logic                 scl_p;
        logic                 sda_m;
        logic                 sda_s;
        logic                 sda_p;
        logic [1:0]           strap_m;
        logic [1:0]           strap_s;
        logic                 strap_ok;
        logic [1:0]           sid;
        smbsp_dst_t           st;
        logic [3:0]           cnt;
        logic [7:0]           sh;
        logic                 rw;
        logic [1:0]           nbyte;
        logic [7:0]           ptr;
        logic                 wr_stb;
        logic [7:0]           wr_data;
        logic                 sda_low;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic                 pin_low;
    } smbsp_dreg_t;

    smbsp_dreg_t r_ff;
    smbsp_dreg_t nxt_r;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        addr_hit;

    localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_PULSE_CYC);

    // only the second and third stages are looked at
    assign scl_rise  = r_ff.scl_s & ~r_ff.scl_p;
    assign scl_fall  = ~r_ff.scl_s & r_ff.scl_p;
    assign start_det = r_ff.scl_s & r_ff.scl_p
                     & r_ff.sda_p & ~r_ff.sda_s;    // see RQ5
    assign stop_det  = r_ff.scl_s & r_ff.scl_p
                     & ~r_ff.sda_p & r_ff.sda_s;    // see RQ9
    assign addr_hit  = r_ff.sh[7:1] == {SLV_PREFIX, r_ff.sid}; // see RQ1

    // ==========================================================
    // next state
    always_comb begin
        nxt_r         = r_ff;
        nxt_r.wr_stb  = 1'b0;
        nxt_r.scl_m   = bus.scl;
        nxt_r.scl_s   = r_ff.scl_m;
        nxt_r.scl_p   = r_ff.scl_s;
        nxt_r.sda_m   = bus.sda;
        nxt_r.sda_s   = r_ff.sda_m;
        nxt_r.sda_p   = r_ff.sda_s;
        nxt_r.strap_m = bus.pin_strap;
        nxt_r.strap_s = r_ff.strap_m;

        // strap is frozen at the first low seen on either line
        if (!r_ff.strap_ok && (!r_ff.scl_s || !r_ff.sda_s)) begin // see RQ4
            nxt_r.strap_ok = 1'b1;
            case (r_ff.strap_s)                                 // see RQ2
                STRAP_GND:  nxt_r.sid = SID_GND;
                STRAP_VCC:  nxt_r.sid = SID_VCC;
                default:    nxt_r.sid = SID_OPEN;               // see RQ3
            endcase
        end

        if (start_det) begin                                // see RQ12
            nxt_r.st      = D_ADDR;
            nxt_r.cnt     = 4'h0;
            nxt_r.nbyte   = 2'h0;
            nxt_r.sda_low = 1'b0;
        end else if (stop_det) begin                        // see RQ10
            nxt_r.st      = D_IDLE;
            nxt_r.sda_low = 1'b0;
        end else begin
            case (r_ff.st)
                D_ADDR: begin
                    if (scl_rise) begin                     // see RQ5
                        nxt_r.sh  = {r_ff.sh[6:0], r_ff.sda_s};
                        nxt_r.cnt = r_ff.cnt + 4'h1;
                    end else if (scl_fall && r_ff.cnt == BITS_BYTE) begin
                        if (addr_hit) begin                 // see RQ6
                            nxt_r.st      = D_AACK;
                            nxt_r.sda_low = 1'b1;
                            nxt_r.rw      = r_ff.sh[0];     // see RQ7
                        end else begin
                            nxt_r.st = D_IGNR;
                        end
                    end
                end
                D_AACK: begin
                    if (scl_fall) begin
                        nxt_r.cnt = 4'h0;
                        if (r_ff.rw == DIR_READ) begin      // see RQ16
                            nxt_r.st      = D_RD;
                            nxt_r.sh      = i_rd_data;
                            nxt_r.sda_low = ~i_rd_data[7];
                        end else begin
                            nxt_r.st      = D_WR;
                            nxt_r.sda_low = 1'b0;
                        end
                    end
                end
                D_WR: begin
                    if (scl_rise) begin                     // see RQ8
                        nxt_r.sh  = {r_ff.sh[6:0], r_ff.sda_s};
                        nxt_r.cnt = r_ff.cnt + 4'h1;
                    end else if (scl_fall && r_ff.cnt == BITS_BYTE) begin
                        // a third byte is left unacknowledged
                        if (r_ff.nbyte < MAX_WR_BYTES) begin // see RQ13
                            nxt_r.st      = D_WACK;
                            nxt_r.sda_low = 1'b1;           // see RQ8
                            nxt_r.nbyte   = r_ff.nbyte + 2'h1;
                            if (r_ff.nbyte == 2'h0) begin
                                nxt_r.ptr = r_ff.sh;        // see RQ14
                            end else begin
                                nxt_r.wr_stb  = 1'b1;       // see RQ15
                                nxt_r.wr_data = r_ff.sh;
                            end
                        end else begin
                            nxt_r.st = D_IGNR;
                        end
                    end
                end
                D_WACK: begin
                    if (scl_fall) begin
                        nxt_r.st      = D_WR;
                        nxt_r.cnt     = 4'h0;
                        nxt_r.sda_low = 1'b0;
                    end
                end
                D_RD: begin
                    if (scl_rise) begin
                        nxt_r.cnt = r_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r_ff.cnt == BITS_BYTE) begin
                            // one byte per read, whatever the master acks
                            nxt_r.st      = D_IGNR;         // see RQ22
                            nxt_r.sda_low = 1'b0;
                        end else begin                      // see RQ9
                            nxt_r.sh      = {r_ff.sh[6:0], 1'b0};
                            nxt_r.sda_low = ~r_ff.sh[6];
                        end
                    end
                end
                D_IDLE, D_IGNR: begin
                    nxt_r.sda_low = 1'b0;
                end
                default: begin
                    nxt_r.st      = D_IDLE;
                    nxt_r.sda_low = 1'b0;
                end
            endcase
        end

        // reset pulse: retrigger ignored while one is running
        if (i_role == ROLE_RESET && i_rst_fire
            && r_ff.rst_cnt == '0) begin                    // see RQ18
            nxt_r.rst_cnt = RST_LOAD;
        end else if (r_ff.rst_cnt != '0) begin
            nxt_r.rst_cnt = r_ff.rst_cnt - 1'b1;
        end

        if (i_nand_test) begin
            nxt_r.pin_low = ~i_nand_tree;                   // see RQ20
        end else begin
            case (i_role)
                ROLE_RESET: nxt_r.pin_low = nxt_r.rst_cnt != '0;
                ROLE_INT:   nxt_r.pin_low = i_alert;        // see RQ19
                default:    nxt_r.pin_low = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r_ff         <= '0;
            r_ff.scl_m   <= 1'b1;
            r_ff.scl_s   <= 1'b1;
            r_ff.scl_p   <= 1'b1;
            r_ff.sda_m   <= 1'b1;
            r_ff.sda_s   <= 1'b1;
            r_ff.sda_p   <= 1'b1;
            r_ff.st      <= D_IDLE;
        end else begin
            r_ff <= nxt_r;                                  // see RQ23
        end
    end

    assign bus.dev_sda_o    = 1'b0;
    assign bus.dev_sda_oe_n = ~r_ff.sda_low;
    assign bus.pin_o        = 1'b0;
    assign bus.pin_oe_n     = ~r_ff.pin_low;
    assign o_reg_addr       = r_ff.ptr;
    assign o_wr_data        = r_ff.wr_data;
    assign o_wr_stb         = r_ff.wr_stb;
    assign o_slave_id       = r_ff.sid;
endmodule

// ==== design/smbsp_host.sv ====
// smbsp_host: bus master end that runs one monitor transfer per request.
// assumes the slave never stretches the clock.
`timescale 1ns/10ps
module smbsp_host (
    input  logic                 i_clk,
    input  logic                 i_rst_n,
    smbsp_if.host                bus,
    input  logic                 i_req,
    input  smbsp_pkg::smbsp_op_t i_op,
    input  logic [6:0]           i_slave_addr,
    input  logic [7:0]           i_ptr,
    input  logic [7:0]           i_data,
    output logic                 o_busy,
    output logic                 o_done,
    output logic                 o_acked,
    output logic [7:0]           o_rd_data
);
    import smbsp_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic       sda_m;
        logic       sda_s;
        smbsp_hst_t st;
        logic [3:0] tc;
        logic [1:0] q;
        logic       scl;
        logic       sda_low;
        logic       rd;
        logic [1:0] bi;
        logic [1:0] nb;
        logic [3:0] bc;
        logic [7:0] sh;
        logic [7:0] b1;
        logic [7:0] b2;
        logic       acked;
        logic       done;
        logic [7:0] rd_data;
    } smbsp_hreg_t;

    smbsp_hreg_t r_ff;
    smbsp_hreg_t nxt_r;
    logic        tick;
    logic        rd_byte;

    assign tick    = r_ff.tc == QTR_CYC - 4'h1;
    assign rd_byte = r_ff.rd && r_ff.bi != 2'h0;

    // ==========================================================
    // next state: each bit is four quarters, sda moves a quarter
    // after scl falls so the slave never sees a false start or stop
    always_comb begin
        nxt_r       = r_ff;
        nxt_r.done  = 1'b0;
        nxt_r.sda_m = bus.sda;
        nxt_r.sda_s = r_ff.sda_m;
        nxt_r.tc    = (r_ff.st == H_IDLE || tick) ? 4'h0 : r_ff.tc + 4'h1;
        if (tick) begin
            nxt_r.q = r_ff.q + 2'h1;
        end
        case (r_ff.st)
            H_IDLE: begin
                nxt_r.q = 2'h0;
                if (i_req) begin
                    nxt_r.st    = H_START;
                    nxt_r.rd    = i_op == OP_READ;
                    nxt_r.nb    = (i_op == OP_WRITE) ? 2'h2 : 2'h1;
                    nxt_r.sh    = {i_slave_addr,
                                   (i_op == OP_READ) ? DIR_READ : DIR_WRITE};
                    nxt_r.b1    = i_ptr;
                    nxt_r.b2    = i_data;
                    nxt_r.bi    = 2'h0;
                    nxt_r.bc    = 4'h0;
                    nxt_r.acked = 1'b1;
                end
            end
            H_START: begin
                if (tick && r_ff.q == 2'h0) begin
                    nxt_r.sda_low = 1'b1;                   // see RQ5
                end else if (tick && r_ff.q == 2'h3) begin
                    nxt_r.scl = 1'b0;
                    nxt_r.st  = H_BIT;
                end
            end
            H_BIT: begin
                if (tick) begin
                    case (r_ff.q)
                        2'h0: nxt_r.sda_low = (r_ff.bc < BITS_BYTE)
                                            & ~rd_byte & ~r_ff.sh[7];
                        2'h1: nxt_r.scl = 1'b1;
                        2'h2: begin
                            if (r_ff.bc < BITS_BYTE) begin
                                nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s};
                            end else if (!rd_byte && r_ff.sda_s) begin
                                nxt_r.acked = 1'b0;
                            end
                        end
                        default: begin
                            nxt_r.scl = 1'b0;
                            if (r_ff.bc == BITS_BYTE) begin // see RQ8
                                nxt_r.bc = 4'h0;
                                nxt_r.bi = r_ff.bi + 2'h1;
                                nxt_r.sh = (r_ff.bi == 2'h0) ? r_ff.b1
                                                             : r_ff.b2;
                                if (rd_byte) begin
                                    nxt_r.rd_data = r_ff.sh;
                                end
                                // a refused byte ends the transfer early
                                if (r_ff.bi == r_ff.nb || !r_ff.acked) begin
                                    nxt_r.st = H_STOP;      // see RQ13
                                end
                            end else begin
                                nxt_r.bc = r_ff.bc + 4'h1;
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    case (r_ff.q)
                        2'h0: nxt_r.sda_low = 1'b1;         // see RQ11
                        2'h1: nxt_r.scl = 1'b1;
                        2'h2: nxt_r.sda_low = 1'b0;         // see RQ10
                        default: begin
                            nxt_r.st   = H_IDLE;
                            nxt_r.done = 1'b1;
                        end
                    endcase
                end
            end
            default: nxt_r.st = H_IDLE;
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r_ff       <= '0;
            r_ff.sda_m <= 1'b1;
            r_ff.sda_s <= 1'b1;
            r_ff.scl   <= 1'b1;
            r_ff.acked <= 1'b1;
            r_ff.st    <= H_IDLE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign bus.scl           = r_ff.scl;
    assign bus.host_sda_o    = 1'b0;
    assign bus.host_sda_oe_n = ~r_ff.sda_low;
    assign o_busy            = r_ff.st != H_IDLE;
    assign o_done            = r_ff.done;
    assign o_acked           = r_ff.acked;
    assign o_rd_data         = r_ff.rd_data;
endmodule

// ==== verif/smbsp_asserts.sv ====
// smbsp_asserts: link checker between the host and device ends.
// assumes raw link levels sampled on the shared 100 MHz clock.
`timescale 1ns/10ps
module smbsp_asserts
    import smbsp_pkg::*;
(
    input logic i_clk,
    input logic i_rst_n,
    input logic scl,
    input logic sda,
    input logic dev_sda_oe_n,
    input logic host_sda_oe_n
);
    // ==========================================================
    // link decode
    logic       scl_ff;
    logic       sda_ff;
    logic       rd_ff;
    logic [5:0] nbit_ff;
    logic [7:0] sh_ff;
    wire        rise  = scl & ~scl_ff;
    wire        start = scl & scl_ff & sda_ff & ~sda;
    wire        stop  = scl & scl_ff & ~sda_ff & sda;

    // nbit_ff counts clock rises since start, so ack slots are 8, 17, 26
    always_ff @(posedge i_clk) begin
        scl_ff <= scl;
        sda_ff <= sda;
        if (!i_rst_n || start) begin
            nbit_ff <= 6'h00;
        end else if (rise) begin
            nbit_ff <= nbit_ff + 6'h01;
        end
        if (!i_rst_n) begin
            rd_ff <= 1'b0;
        end else if (rise && nbit_ff == 6'h07) begin
            rd_ff <= sda;
        end
        if (rise) begin
            sh_ff <= {sh_ff[6:0], sda};
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_ack_own_prefix: assert property (
        rise && nbit_ff == 6'h08 && !dev_sda_oe_n |-> sh_ff[7:3] == SLV_PREFIX)
        else $error("ack given to foreign prefix");
    a_no_stray_pull: assert property (
        rise && (nbit_ff < 6'h08 || (!rd_ff && (nbit_ff % 9) != 8))
        |-> dev_sda_oe_n) else $error("device pulls data off its slot");
    a_read_one_byte: assert property (
        rise && rd_ff && nbit_ff >= 6'h11 |-> dev_sda_oe_n)
        else $error("device drives after read byte");
    a_dev_stable_high: assert property (
        scl && $past(scl) |-> $stable(dev_sda_oe_n))
        else $error("device data moved while clock high");
    a_scl_low_len: assert property (
        $fell(scl) |=> !scl [*7] ##1 scl)
        else $error("clock low phase not 8 cycles");
    a_stop_idle: assert property (
        stop |=> dev_sda_oe_n [*8]) else $error("device active after stop");
    a_host_release: assert property (
        rise && (nbit_ff == 6'h08 || (rd_ff && nbit_ff inside {[9:17]}))
        |-> host_sda_oe_n) else $error("host drives a slave slot");
    a_start_hold: assert property (
        start |=> scl [*8]) else $error("clock fell too soon after start");

    cover property (rise && nbit_ff == 6'h08 && !dev_sda_oe_n && rd_ff);
    cover property (rise && nbit_ff == 6'h11 && !dev_sda_oe_n && !rd_ff);
    cover property (stop);
endmodule

// ==== verif/tb_top.sv ====
// tb_top: host end and device end joined over one link interface.
// assumes the register file answers pointer xor A5 at once.
`timescale 1ns/10ps
module tb_top;
    import smbsp_pkg::*;
    localparam int unsigned PULSE = 50;
    logic        clk, rst_n, req, ntest, ntree, fire, alert;
    logic        busy, done, acked, wr_stb;
    logic [6:0]  saddr;
    logic [7:0]  ptr, data, rdd, rd_data, reg_addr, wr_data, ptr_m;
    logic [1:0]  sid;
    smbsp_op_t   op, k;
    smbsp_role_t role;
    logic [9:0]  q_done[$];
    logic [15:0] q_wr[$];
    logic [9:0]  note;
    int          fails, compares, n;
    logic [6:0]  adr_t[3]   = '{7'h2C, 7'h2E, 7'h2D};
    logic [1:0]  sid_t[3]   = '{2'h0, 2'h2, 2'h1};
    logic [1:0]  strap_t[3] = '{STRAP_GND, STRAP_OPEN, STRAP_VCC};

    smbsp_if bus_if ();
    smbsp_dev #(.RST_PULSE_CYC(PULSE)) smbsp_dev_i (
        .i_clk(clk), .i_rst_n(rst_n), .bus(bus_if), .i_role(role),
        .i_nand_test(ntest), .i_nand_tree(ntree), .i_rst_fire(fire),
        .i_alert(alert), .i_rd_data(rd_data), .o_reg_addr(reg_addr),
        .o_wr_data(wr_data), .o_wr_stb(wr_stb), .o_slave_id(sid));
    smbsp_host smbsp_host_i (
        .i_clk(clk), .i_rst_n(rst_n), .bus(bus_if), .i_req(req),
        .i_op(op), .i_slave_addr(saddr), .i_ptr(ptr), .i_data(data),
        .o_busy(busy), .o_done(done), .o_acked(acked), .o_rd_data(rdd));
    smbsp_asserts smbsp_asserts_i (
        .i_clk(clk), .i_rst_n(rst_n), .scl(bus_if.scl), .sda(bus_if.sda),
        .dev_sda_oe_n(bus_if.dev_sda_oe_n),
        .host_sda_oe_n(bus_if.host_sda_oe_n));

    // register contents are a fixed mask of the pointer
    assign rd_data = reg_addr ^ 8'hA5;

    // ==========================================================
    // checking
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // oldest note is matched to each completion or write strobe
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (q_done.size() == 0) begin
                chk(17'h1, 17'h0);
            end else begin
                // the read flag steers the compare and is not compared
                note = q_done.pop_front();
                if (note[9]) begin
                    chk(17'({acked, rdd}), 17'(note[8:0]));
                end else begin
                    chk(17'(acked), 17'(note[8]));
                end
            end
        end
        if (wr_stb === 1'b1) begin
            chk(17'({reg_addr, wr_data}), 17'(q_wr.pop_front()));
        end
    end

    // ==========================================================
    // stimulus
    task automatic reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        ptr_m = 8'h00;
    endtask

    // one transfer; a refused address leaves the pointer alone
    task automatic run(input smbsp_op_t c, input logic [6:0] a,
                       input logic [7:0] p, input logic [7:0] d,
                       input logic ok);
        int w;
        w = 0;
        q_done.push_back({c == OP_READ, ok, ptr_m ^ 8'hA5});
        if (c == OP_WRITE && ok) q_wr.push_back({p, d});
        @(posedge clk);
        req <= 1'b1;
        op <= c;
        saddr <= a;
        ptr <= p;
        data <= d;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        chk(17'(busy), 17'h1);
        while (done !== 1'b1 && w < 1000) begin
            @(posedge clk);
            w++;
        end
        if (w >= 1000) fails++;
        if (c != OP_READ && ok) ptr_m = p;
    endtask

    task automatic pin_chk(input logic e);
        repeat (3) @(posedge clk);
        chk(17'(bus_if.pin_oe_n), 17'(e));
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #600000;
        fails++;
        end_sim();
    end

    initial begin
        rst_n <= 1'b0;
        req <= 1'b0;
        op <= OP_SET_PTR;
        saddr <= 7'h00;
        ptr <= 8'h00;
        data <= 8'h00;
        role <= ROLE_ADDR;
        ntest <= 1'b0;
        ntree <= 1'b0;
        fire <= 1'b0;
        alert <= 1'b0;
        void'($urandom(96));
        for (int s = 0; s < 3; s++) begin
            bus_if.pin_strap <= strap_t[s];
            reset();
            run(OP_SET_PTR, adr_t[s] ^ 7'h01, 8'h11, 8'h00, 1'b0);
            run(OP_SET_PTR, adr_t[s], 8'($urandom), 8'h00, 1'b1);
            chk(17'(sid), 17'(sid_t[s]));
            $display("strap test %0d done", s);
        end
        // strap moved after latch must not change the address
        bus_if.pin_strap <= STRAP_GND;
        run(OP_READ, 7'h2D, 8'h00, 8'h00, 1'b1);
        chk(17'(sid), 17'h1);
        $display("strap hold test done");
        for (int i = 0; i < 12; i++) begin
            k = (i < 3) ? smbsp_op_t'(i) : smbsp_op_t'($urandom % 3);
            run(k, 7'h2D, 8'($urandom), 8'($urandom), 1'b1);
            chk(17'(reg_addr), 17'(ptr_m));
        end
        $display("transfer test done");
        // a grounded strap would pin the multi-role line low for good
        bus_if.pin_strap <= STRAP_OPEN;
        pin_chk(1'b1);
        role <= ROLE_INT;
        alert <= 1'b1;
        pin_chk(1'b0);
        alert <= 1'b0;
        pin_chk(1'b1);
        role <= ROLE_RESET;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        n = 0;
        repeat (PULSE + 20) begin
            @(posedge clk);
            if (bus_if.pin_oe_n === 1'b0) n++;
        end
        chk(17'(n), 17'(PULSE));
        ntest <= 1'b1;
        pin_chk(1'b0);
        ntree <= 1'b1;
        pin_chk(1'b1);
        $display("pin role test done");
        end_sim();
    end
endmodule
